// ==== design/sbm_pkg.sv ====
package sbm_pkg;
    localparam int CLK_HZ = 50000000;
    localparam int SCL_NORMAL_HZ = 60000;
    localparam int SCL_TEST_HZ = 4000000;
    // Each serial bit is four quarter periods long
    localparam int QUARTERS_PER_BIT = 4;
    localparam int QTR_NORMAL = CLK_HZ / (QUARTERS_PER_BIT * SCL_NORMAL_HZ);
    localparam int QTR_TEST = CLK_HZ / (QUARTERS_PER_BIT * SCL_TEST_HZ);
    localparam int DIV_W = 8;

    localparam logic [7:0] OFS_BYTE_DATA = 8'hb0;
    localparam logic [7:0] OFS_WORD_LOCATION = 8'hb1;
    localparam logic [7:0] OFS_TARGET_SELECT = 8'hb2;
    localparam logic [7:0] OFS_CONTROL_STATUS = 8'hb3;

    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [6:0] RESET_TARGET = 7'h00;

    localparam int TGT_DIR_BIT = 0;
    localparam int CS_PROT_SEL = 7;
    localparam int CS_RSVD = 6;
    localparam int CS_REQ_BUSY = 5;
    localparam int CS_LOAD_BUSY = 4;
    localparam int CS_PRESENT = 3;
    localparam int CS_FAST = 2;
    localparam int CS_SER_ERR = 1;
    localparam int CS_LOAD_ERR = 0;

    localparam logic [2:0] LAST_BIT = 3'h7;

    typedef enum logic [2:0] {
        SBM_IDLE, SBM_START, SBM_SEND, SBM_GET_ACK, SBM_RECV, SBM_PUT_NACK, SBM_STOP
    } sbm_state_t;

    typedef enum logic [1:0] {
        SBM_STG_ADDR, SBM_STG_WORD, SBM_STG_RADDR, SBM_STG_DATA
    } sbm_stage_t;
endpackage

// ==== design/sbm_serial_bus_byte_master.sv ====
// Overview of operation
// - After a read, the data register holds the received byte once busy clears.
// - A write to target-select while the sequencer is idle starts one serial cycle with current registers.
// - Target-select bits 7:1 hold the 7-bit target address, reset to zero.
// - Target-select bit 0 selects write (0) or read (1), reset to zero.
// - Control bit 7 zero sends target and word address; one sends target only.
// - Status bit 5 reads one for the whole software cycle, else zero.
// - Status bit 4 reads one while the loader fetches EEPROM defaults.
// - Status bit 3 sets when an EEPROM is present at link reset release.
// - Control bit 2 selects about 60 kHz normally or about 4 MHz for test.
// - Status bit 1 sets on a software cycle error and stays until cleared.
// - Status bit 0 sets on a loader error and stays until cleared.
// - All registers clear on link reset, global reset or power-on reset.
// - Control bit 6 always reads zero and ignores writes.
`timescale 1ns/10ps
module sbm_serial_bus_byte_master
    import sbm_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic link_reset_n,
    input wire logic global_reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic loader_busy,
    input wire logic loader_error,
    input wire logic loader_eeprom_found,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    output logic scl_out,
    output logic scl_oe_n
);
    localparam logic [DIV_W-1:0] QTR_NORMAL_LAST = DIV_W'(QTR_NORMAL - 1);
    localparam logic [DIV_W-1:0] QTR_TEST_LAST = DIV_W'(QTR_TEST - 1);

    // Pin and reset synchronisers
    logic sda_s1, sda_s2;
    logic link_s1, link_s2, link_s3;
    logic glob_s1, glob_s2;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            link_s1 <= 1'b0;
            link_s2 <= 1'b0;
            link_s3 <= 1'b0;
            glob_s1 <= 1'b0;
            glob_s2 <= 1'b0;
        end else begin
            sda_s1 <= sda_in;
            sda_s2 <= sda_s1;
            link_s1 <= link_reset_n;
            link_s2 <= link_s1;
            link_s3 <= link_s2;
            glob_s1 <= global_reset_n;
            glob_s2 <= glob_s1;
        end
    end

    logic soft_clr;
    logic link_release;
    assign soft_clr = !link_s2 || !glob_s2;
    assign link_release = link_s2 && !link_s3;

    // Quarter-bit enable from the core clock
    logic fast_sel;
    logic [DIV_W-1:0] div_cnt, next_div_cnt;
    logic tick, next_tick;

    always_comb begin
        logic [DIV_W-1:0] last;
        last = fast_sel ? QTR_TEST_LAST : QTR_NORMAL_LAST;
        next_div_cnt = div_cnt + 1'b1;
        next_tick = 1'b0;
        if (soft_clr || div_cnt >= last) begin
            next_div_cnt = '0;
            next_tick = !soft_clr;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            div_cnt <= '0;
            tick <= 1'b0;
        end else begin
            div_cnt <= next_div_cnt;
            tick <= next_tick;
        end
    end

    // Registers and the cycle sequencer
    logic [7:0] byte_data, next_byte_data;
    logic [7:0] word_loc, next_word_loc;
    logic [6:0] tgt_addr, next_tgt_addr;
    logic tgt_read, next_tgt_read;
    logic prot_sel, next_prot_sel;
    logic req_busy, next_req_busy;
    logic present, next_present;
    logic next_fast_sel;
    logic ser_err, next_ser_err;
    logic load_err, next_load_err;
    sbm_state_t state, next_state;
    sbm_stage_t stage, next_stage;
    logic [1:0] qtr, next_qtr;
    logic [2:0] bit_cnt, next_bit_cnt;
    logic [7:0] shift, next_shift;
    logic ack_bit, next_ack_bit;
    logic scl_low, next_scl_low;
    logic sda_low, next_sda_low;
    logic [7:0] next_rdata;

    logic wr_data, wr_word, wr_tgt, wr_cs;
    assign wr_data = reg_write && reg_addr == OFS_BYTE_DATA;
    assign wr_word = reg_write && reg_addr == OFS_WORD_LOCATION;
    assign wr_tgt = reg_write && reg_addr == OFS_TARGET_SELECT;
    assign wr_cs = reg_write && reg_addr == OFS_CONTROL_STATUS;

    always_comb begin
        logic [7:0] cs_view;
        cs_view = RESET_BYTE;
        cs_view[CS_PROT_SEL] = prot_sel;
        cs_view[CS_RSVD] = 1'b0;
        cs_view[CS_REQ_BUSY] = req_busy;
        cs_view[CS_LOAD_BUSY] = loader_busy;
        cs_view[CS_PRESENT] = present;
        cs_view[CS_FAST] = fast_sel;
        cs_view[CS_SER_ERR] = ser_err;
        cs_view[CS_LOAD_ERR] = load_err;

        next_byte_data = byte_data;
        next_word_loc = word_loc;
        next_tgt_addr = tgt_addr;
        next_tgt_read = tgt_read;
        next_prot_sel = prot_sel;
        next_req_busy = req_busy;
        next_present = present;
        next_fast_sel = fast_sel;
        next_ser_err = ser_err;
        next_load_err = load_err;
        next_state = state;
        next_stage = stage;
        next_qtr = qtr;
        next_bit_cnt = bit_cnt;
        next_shift = shift;
        next_ack_bit = ack_bit;
        next_scl_low = scl_low;
        next_sda_low = sda_low;
        next_rdata = reg_rdata;

        if (reg_read) begin
            case (reg_addr)
                OFS_BYTE_DATA: next_rdata = byte_data;
                OFS_WORD_LOCATION: next_rdata = word_loc;
                OFS_TARGET_SELECT: next_rdata = {tgt_addr, tgt_read};
                OFS_CONTROL_STATUS: next_rdata = cs_view;
                default: next_rdata = RESET_BYTE;
            endcase
        end

        if (wr_data) begin
            next_byte_data = reg_wdata;
        end
        if (wr_word) begin
            next_word_loc = reg_wdata;
        end
        if (wr_cs) begin
            next_prot_sel = reg_wdata[CS_PROT_SEL];
            next_fast_sel = reg_wdata[CS_FAST];
            // Write one to clear; a same-cycle event below still wins
            if (reg_wdata[CS_SER_ERR]) begin
                next_ser_err = 1'b0;
            end
            if (reg_wdata[CS_LOAD_ERR]) begin
                next_load_err = 1'b0;
            end
        end
        if (loader_error) begin
            next_load_err = 1'b1;
        end
        if (link_release) begin
            next_present = loader_eeprom_found;
        end

        // A write while busy would corrupt the byte on the wire, so it is ignored
        if (wr_tgt && state == SBM_IDLE) begin
            next_tgt_addr = reg_wdata[7:1];
            next_tgt_read = reg_wdata[TGT_DIR_BIT];
            next_req_busy = 1'b1;
            next_state = SBM_START;
            next_stage = SBM_STG_ADDR;
            next_qtr = 2'h0;
        end else if (tick && state != SBM_IDLE) begin
            next_qtr = 2'(qtr + 2'h1);
            case (state)
                SBM_START: begin
                    // Both the first and the repeated start; SDA falls a quarter
                    // after SCL is released so the two never move on one edge
                    next_scl_low = (qtr == 2'h0 && scl_low) || qtr == 2'h3;
                    next_sda_low = qtr >= 2'h2;
                    if (qtr == 2'h3) begin
                        next_state = SBM_SEND;
                        next_bit_cnt = LAST_BIT;
                        if (stage == SBM_STG_RADDR) begin
                            next_shift = {tgt_addr, 1'b1};
                        end else begin
                            next_shift = {tgt_addr, prot_sel & tgt_read};
                        end
                    end
                end
                SBM_SEND: begin
                    next_scl_low = qtr < 2'h1 || qtr == 2'h3;
                    next_sda_low = !shift[7];
                    if (qtr == 2'h3) begin
                        next_scl_low = 1'b1;
                        if (bit_cnt == 3'h0) begin
                            next_state = SBM_GET_ACK;
                        end else begin
                            next_shift = {shift[6:0], 1'b0};
                            next_bit_cnt = 3'(bit_cnt - 3'h1);
                        end
                    end
                end
                SBM_GET_ACK, SBM_RECV, SBM_PUT_NACK: begin
                    next_sda_low = 1'b0;
                    next_scl_low = qtr == 2'h3 || qtr == 2'h0;
                    if (qtr == 2'h2) begin
                        if (state == SBM_GET_ACK) begin
                            next_ack_bit = sda_s2;
                        end else if (state == SBM_RECV) begin
                            next_shift = {shift[6:0], sda_s2};
                        end
                    end
                    if (qtr == 2'h3) begin
                        next_scl_low = 1'b1;
                        if (state == SBM_PUT_NACK) begin
                            next_state = SBM_STOP;
                        end else if (state == SBM_RECV) begin
                            if (bit_cnt == 3'h0) begin
                                next_byte_data = shift;
                                next_state = SBM_PUT_NACK;
                            end else begin
                                next_bit_cnt = 3'(bit_cnt - 3'h1);
                            end
                        end else if (ack_bit) begin
                            next_ser_err = 1'b1;
                            next_state = SBM_STOP;
                        end else begin
                            next_bit_cnt = LAST_BIT;
                            case (stage)
                                SBM_STG_ADDR: begin
                                    if (!prot_sel) begin
                                        next_stage = SBM_STG_WORD;
                                        next_shift = word_loc;
                                        next_state = SBM_SEND;
                                    end else if (tgt_read) begin
                                        next_stage = SBM_STG_DATA;
                                        next_state = SBM_RECV;
                                    end else begin
                                        next_stage = SBM_STG_DATA;
                                        next_shift = byte_data;
                                        next_state = SBM_SEND;
                                    end
                                end
                                SBM_STG_WORD: begin
                                    if (tgt_read) begin
                                        next_stage = SBM_STG_RADDR;
                                        next_state = SBM_START;
                                    end else begin
                                        next_stage = SBM_STG_DATA;
                                        next_shift = byte_data;
                                        next_state = SBM_SEND;
                                    end
                                end
                                SBM_STG_RADDR: begin
                                    next_stage = SBM_STG_DATA;
                                    next_state = SBM_RECV;
                                end
                                default: next_state = SBM_STOP;
                            endcase
                        end
                    end
                end
                SBM_STOP: begin
                    next_scl_low = qtr == 2'h0;
                    next_sda_low = qtr <= 2'h1;
                    if (qtr == 2'h3) begin
                        next_state = SBM_IDLE;
                        next_req_busy = 1'b0;
                    end
                end
                default: next_state = SBM_IDLE;
            endcase
        end

        if (soft_clr) begin
            next_byte_data = RESET_BYTE;
            next_word_loc = RESET_BYTE;
            next_tgt_addr = RESET_TARGET;
            next_tgt_read = 1'b0;
            next_prot_sel = 1'b0;
            next_req_busy = 1'b0;
            next_present = 1'b0;
            next_fast_sel = 1'b0;
            next_ser_err = 1'b0;
            next_load_err = 1'b0;
            next_state = SBM_IDLE;
            next_stage = SBM_STG_ADDR;
            next_qtr = 2'h0;
            next_scl_low = 1'b0;
            next_sda_low = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            byte_data <= RESET_BYTE;
            word_loc <= RESET_BYTE;
            tgt_addr <= RESET_TARGET;
            tgt_read <= 1'b0;
            prot_sel <= 1'b0;
            req_busy <= 1'b0;
            present <= 1'b0;
            fast_sel <= 1'b0;
            ser_err <= 1'b0;
            load_err <= 1'b0;
            state <= SBM_IDLE;
            stage <= SBM_STG_ADDR;
            qtr <= 2'h0;
            bit_cnt <= 3'h0;
            shift <= RESET_BYTE;
            ack_bit <= 1'b0;
            scl_low <= 1'b0;
            sda_low <= 1'b0;
            reg_rdata <= RESET_BYTE;
            sda_out <= 1'b1;
            sda_oe_n <= 1'b1;
            scl_out <= 1'b1;
            scl_oe_n <= 1'b1;
        end else begin
            byte_data <= next_byte_data;
            word_loc <= next_word_loc;
            tgt_addr <= next_tgt_addr;
            tgt_read <= next_tgt_read;
            prot_sel <= next_prot_sel;
            req_busy <= next_req_busy;
            present <= next_present;
            fast_sel <= next_fast_sel;
            ser_err <= next_ser_err;
            load_err <= next_load_err;
            state <= next_state;
            stage <= next_stage;
            qtr <= next_qtr;
            bit_cnt <= next_bit_cnt;
            shift <= next_shift;
            ack_bit <= next_ack_bit;
            scl_low <= next_scl_low;
            sda_low <= next_sda_low;
            reg_rdata <= next_rdata;
            // Open drain: only ever pull low, release otherwise
            sda_out <= !next_sda_low;
            sda_oe_n <= !next_sda_low;
            scl_out <= !next_scl_low;
            scl_oe_n <= !next_scl_low;
        end
    end
endmodule

// ==== tb/sbm_monitor.sv ====
`timescale 1ns/10ps
module sbm_monitor
    import sbm_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic loader_busy,
    input wire logic loader_error,
    input wire logic sda_oe_n,
    input wire logic scl_oe_n
);
    default clocking mon_cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    wire cs_rd = reg_read && reg_addr == OFS_CONTROL_STATUS;
    sequence s_launch;
        reg_write && reg_addr == OFS_TARGET_SELECT ##1 cs_rd;
    endsequence
    sequence s_err_read;
        cs_rd ##1 cs_rd && reg_rdata[CS_SER_ERR];
    endsequence
    sequence s_err_clear;
        reg_write && reg_addr == OFS_CONTROL_STATUS && reg_wdata[CS_SER_ERR] ##2 cs_rd;
    endsequence
    property p_busy_set;
        s_launch |=> reg_rdata[CS_REQ_BUSY];
    endproperty
    property p_err_sticky;
        s_err_read |=> reg_rdata[CS_SER_ERR];
    endproperty
    property p_err_clear;
        s_err_clear |=> !reg_rdata[CS_SER_ERR];
    endproperty
    property p_rsvd_zero;
        cs_rd |=> !reg_rdata[CS_RSVD];
    endproperty
    property p_load_busy;
        cs_rd |=> reg_rdata[CS_LOAD_BUSY] == $past(loader_busy);
    endproperty
    property p_load_err;
        loader_error ##1 cs_rd |=> reg_rdata[CS_LOAD_ERR];
    endproperty
    property p_data_back;
        reg_write && reg_addr == OFS_BYTE_DATA ##1 reg_read && reg_addr == OFS_BYTE_DATA
            |=> reg_rdata == $past(reg_wdata, 2);
    endproperty
    // Pins must come out of reset released, never mid-frame
    property p_pins_free;
        $rose(reset_n) |-> sda_oe_n && scl_oe_n;
    endproperty
    a_busy_set: assert property (p_busy_set) else $error("busy missing");
    a_err_sticky: assert property (p_err_sticky) else $error("error lost");
    a_err_clear: assert property (p_err_clear) else $error("error kept");
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved set");
    a_load_busy: assert property (p_load_busy) else $error("load busy");
    a_load_err: assert property (p_load_err) else $error("load error");
    a_data_back: assert property (p_data_back) else $error("data lost");
    a_pins_free: assert property (p_pins_free) else $error("pins held");
endmodule
bind sbm_serial_bus_byte_master sbm_monitor u_sbm_monitor (
    .clk, .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .loader_busy, .loader_error, .sda_oe_n, .scl_oe_n
);

// ==== tb/sbm_target.sv ====
`timescale 1ns/10ps
module sbm_target #(
    parameter logic [6:0] TGT_ADDR = 7'h2a
) (
    input wire logic scl,
    input wire logic sda,
    input wire logic nack_all,
    input wire logic no_word,
    output logic sda_low
);
    logic [7:0] mem [0:255];
    logic [7:0] ptr = 8'h00;
    logic [7:0] sh = 8'h00;
    logic hit = 1'b0;
    logic rdir = 1'b0;
    logic tx = 1'b0;
    int cnt = 0;
    int nbyte = 0;
    int bytes_seen = 0;
    initial sda_low = 1'b0;
    always @(negedge sda) begin
        if (scl) begin
            cnt = 0;
            nbyte = 0;
            tx = 1'b0;
        end
    end
    always @(posedge scl) begin
        if (cnt < 8) begin
            sh = {sh[6:0], sda};
        end else if (tx && sda) begin
            tx = 1'b0;
        end
        cnt++;
    end
    // Drive only after SCL falls so the line is settled before the next rise
    always @(negedge scl) begin
        if (cnt == 9) begin
            cnt = 0;
        end
        sda_low = 1'b0;
        if (cnt == 8) begin
            bytes_seen++;
            if (!tx) begin
                if (nbyte == 0) begin
                    hit = sh[7:1] == TGT_ADDR && !nack_all;
                    rdir = sh[0];
                end else if (nbyte == 1 && !no_word) begin
                    ptr = sh;
                end else if (hit) begin
                    mem[ptr] = sh;
                end
                sda_low = hit;
                nbyte++;
                tx = hit && rdir && nbyte == 1;
            end
        end else if (tx) begin
            sda_low = !mem[ptr][7 - cnt];
        end
    end
endmodule

// ==== tb/serial_bus_byte_master_tb.sv ====
`timescale 1ns/10ps
module serial_bus_byte_master_tb
    import sbm_pkg::*;
;
    localparam logic [6:0] TGT = 7'h2a;
    localparam logic [7:0] DAT = OFS_BYTE_DATA;
    localparam logic [7:0] WRD = OFS_WORD_LOCATION;
    localparam logic [7:0] TSL = OFS_TARGET_SELECT;
    localparam logic [7:0] CSR = OFS_CONTROL_STATUS;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic link_reset_n = 1'b0;
    logic global_reset_n = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic loader_busy = 1'b0;
    logic loader_error = 1'b0;
    logic loader_eeprom_found = 1'b1;
    logic nack_all = 1'b0;
    logic no_word = 1'b0;
    logic [7:0] reg_rdata;
    logic sda_out;
    logic sda_oe_n;
    logic scl_out;
    logic scl_oe_n;
    logic sda_low;
    int fails = 0;
    int tests_run = 0;
    int b0 = 0;
    time t0 = 0;
    // Pull-ups: a wire is low only while some party pulls it
    wire sda_bus = !((!sda_oe_n && !sda_out) || sda_low);
    wire scl_bus = !(!scl_oe_n && !scl_out);
    initial begin
        forever #10 clk = ~clk;
    end
    sbm_serial_bus_byte_master u_sbm_serial_bus_byte_master (
        .clk, .reset_n, .link_reset_n, .global_reset_n, .reg_addr, .reg_wdata,
        .reg_write, .reg_read, .reg_rdata, .loader_busy, .loader_error,
        .loader_eeprom_found, .sda_in(sda_bus), .sda_out, .sda_oe_n, .scl_out, .scl_oe_n
    );
    sbm_target #(.TGT_ADDR(TGT)) u_sbm_target (
        .scl(scl_bus), .sda(sda_bus), .nack_all, .no_word, .sda_low
    );
    task chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task print_verdict;
        if (fails == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        reg_write <= w;
        reg_read <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
    endtask
    task idle;
        reg_write <= 1'b0;
        reg_read <= 1'b0;
        @(posedge clk);
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        acc(1'b1, a, d);
        idle;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        acc(1'b0, a, 8'h00);
        idle;
        chk(reg_rdata, e);
    endtask
    task wait_idle;
        int n;
        n = 0;
        do begin
            acc(1'b0, CSR, 8'h00);
            idle;
            n++;
        end while (reg_rdata[CS_REQ_BUSY] !== 1'b0 && n < 20000);
        if (n >= 20000) begin
            fails++;
            print_verdict;
        end
    endtask
    task go(input logic [7:0] sel);
        b0 = u_sbm_target.bytes_seen;
        t0 = $time;
        acc(1'b1, TSL, sel);
        acc(1'b0, CSR, 8'h00);
        idle;
        chk(reg_rdata & 8'h20, 8'h20);
        wait_idle;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        link_reset_n <= 1'b1;
        repeat (8) @(posedge clk);
        rd(DAT, 8'h00);
        rd(WRD, 8'h00);
        rd(TSL, 8'h00);
        rd(CSR, 8'h08);
        wr(CSR, 8'hff);
        rd(CSR, 8'h8c);
        wr(CSR, 8'h04);
        acc(1'b1, DAT, 8'ha5);
        acc(1'b0, DAT, 8'h00);
        idle;
        chk(reg_rdata, 8'ha5);
        wr(WRD, 8'h3c);
        go({TGT, 1'b0});
        chk(u_sbm_target.mem[8'h3c], 8'ha5);
        chk(8'(u_sbm_target.bytes_seen - b0), 8'h03);
        chk(8'(($time - t0) < 32 * 4 * QTR_TEST * 20 + 200), 8'h01);
        rd(TSL, {TGT, 1'b0});
        wr(DAT, 8'h00);
        go({TGT, 1'b1});
        rd(DAT, 8'ha5);
        chk(8'(u_sbm_target.bytes_seen - b0), 8'h04);
        rd(TSL, {TGT, 1'b1});
        wr(CSR, 8'h84);
        no_word <= 1'b1;
        wr(DAT, 8'h00);
        go({TGT, 1'b1});
        rd(DAT, 8'ha5);
        chk(8'(u_sbm_target.bytes_seen - b0), 8'h02);
        nack_all <= 1'b1;
        go({TGT, 1'b0});
        acc(1'b0, CSR, 8'h00);
        acc(1'b0, CSR, 8'h00);
        idle;
        chk(reg_rdata, 8'h8e);
        chk(8'(u_sbm_target.bytes_seen - b0), 8'h01);
        wr(CSR, 8'h86);
        rd(CSR, 8'h8c);
        nack_all <= 1'b0;
        no_word <= 1'b0;
        loader_busy <= 1'b1;
        rd(CSR, 8'h9c);
        loader_busy <= 1'b0;
        loader_error <= 1'b1;
        @(posedge clk);
        loader_error <= 1'b0;
        acc(1'b0, CSR, 8'h00);
        acc(1'b0, CSR, 8'h00);
        idle;
        chk(reg_rdata, 8'h8d);
        wr(CSR, 8'h01);
        rd(CSR, 8'h08);
        wr(DAT, 8'h5a);
        wr(WRD, 8'hc3);
        go({TGT, 1'b0});
        chk(u_sbm_target.mem[8'hc3], 8'h5a);
        chk(8'(($time - t0) > 27 * 4 * QTR_NORMAL * 20), 8'h01);
        loader_eeprom_found <= 1'b0;
        link_reset_n <= 1'b0;
        repeat (6) @(posedge clk);
        link_reset_n <= 1'b1;
        repeat (8) @(posedge clk);
        rd(DAT, 8'h00);
        rd(TSL, 8'h00);
        rd(CSR, 8'h00);
        wr(WRD, 8'h77);
        wr(CSR, 8'h84);
        global_reset_n <= 1'b0;
        repeat (6) @(posedge clk);
        global_reset_n <= 1'b1;
        repeat (8) @(posedge clk);
        rd(WRD, 8'h00);
        rd(CSR, 8'h00);
        print_verdict;
    end
endmodule
